// ===== rtl/adir_pkg.sv
package adir_pkg;

	localparam int unsigned ADIR_DATA_W = 8;
	localparam int unsigned ADIR_IDX_W  = 10;
	localparam int unsigned ADIR_SRC_N  = 2;

	// word indices; byte address is four times the index
	localparam logic [ADIR_IDX_W-1:0] ADIR_CTRL_IDX   = 10'h0FE;
	localparam logic [ADIR_IDX_W-1:0] ADIR_VEC_IDX    = 10'h0FF;
	localparam logic [ADIR_IDX_W-1:0] ADIR_STATUS_IDX = 10'h100;
	localparam logic [ADIR_IDX_W-1:0] ADIR_MASK_IDX   = 10'h101;

	// control register layout
	localparam int unsigned ADIR_CTRL_CONV_FLAG_BIT = 7;
	localparam int unsigned ADIR_CTRL_LIM_FLAG_BIT  = 6;
	localparam int unsigned ADIR_CTRL_CONV_EN_BIT   = 5;
	localparam int unsigned ADIR_CTRL_LIM_EN_BIT    = 4;
	localparam int unsigned ADIR_CTRL_RSVD_BIT      = 3;
	localparam int unsigned ADIR_CTRL_PRIO_LSB      = 0;
	localparam int unsigned ADIR_PRIO_W             = 3;
	localparam logic [ADIR_PRIO_W-1:0] ADIR_PRIO_RST = 3'h7;

	// vector register layout
	localparam int unsigned ADIR_VEC_BASE_LSB = 2;
	localparam int unsigned ADIR_VEC_BASE_W   = 6;
	localparam int unsigned ADIR_VEC_WSEL_BIT = 1;
	localparam logic [ADIR_VEC_BASE_W-1:0] ADIR_VEC_BASE_RST = 6'h00;
	localparam logic                       ADIR_WSEL_RST     = 1'b1;

	// interrupt status / mask layout
	localparam int unsigned ADIR_EVT_CONV_BIT = 0;
	localparam int unsigned ADIR_EVT_LIM_BIT  = 1;
	localparam logic [ADIR_SRC_N-1:0] ADIR_STATUS_RST = 2'h0;
	localparam logic [ADIR_SRC_N-1:0] ADIR_MASK_RST   = 2'h0;

	// word select encodings
	localparam logic ADIR_WSEL_LIMIT = 1'b0;
	localparam logic ADIR_WSEL_CONV  = 1'b1;

	localparam logic [1:0] ADIR_HTRANS_NONSEQ = 2'h2;

endpackage

// ===== rtl/adir_arb_if.sv
`timescale 1ns/10ps
interface adir_arb_if;
	logic conv_req;
	logic lim_req;
	logic word_sel;
	logic req_any;

	modport ctl (
		output conv_req,
		output lim_req,
		input  word_sel,
		input  req_any
	);

	modport arb (
		input  conv_req,
		input  lim_req,
		output word_sel,
		output req_any
	);
endinterface

// ===== rtl/adir_arbiter.sv
`timescale 1ns/10ps
module adir_arbiter (
	input wire logic hclk,
	input wire logic hresetn,
	adir_arb_if.arb  arb
);
	import adir_pkg::*;

	logic word_sel_ff;
	logic nxt_word_sel;

	////////////////////////////////////////////////////////////////
	// watchdog wins; the other request stays pending behind it
	always_comb begin
		nxt_word_sel = word_sel_ff;
		if (arb.lim_req) begin
			nxt_word_sel = ADIR_WSEL_LIMIT;
		end else if (arb.conv_req) begin
			nxt_word_sel = ADIR_WSEL_CONV;
		end
	end

	// holds last source when idle so a late vector fetch still points right
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_sel_ff <= ADIR_WSEL_RST;
		end else begin
			word_sel_ff <= nxt_word_sel;
		end
	end

	assign arb.word_sel = word_sel_ff;
	assign arb.req_any  = arb.lim_req | arb.conv_req;

endmodule

// ===== rtl/adir_top.sv
`timescale 1ns/10ps
module adir_top (
	input  wire logic                             hclk,
	input  wire logic                             hresetn,
	input  wire logic                             hsel,
	input  wire logic [31:0]                      haddr,
	input  wire logic [1:0]                       htrans,
	input  wire logic                             hwrite,
	input  wire logic [2:0]                       hsize,
	input  wire logic [31:0]                      hwdata,
	input  wire logic                             hready,
	output logic      [31:0]                      hrdata,
	output logic                                  hreadyout,
	output logic                                  hresp,
	input  wire logic                             conv_group_done,
	input  wire logic                             limit_violation,
	output logic                                  cpu_irq_req,
	output logic      [adir_pkg::ADIR_PRIO_W-1:0] irq_priority_level,
	output logic      [adir_pkg::ADIR_DATA_W-1:0] irq_vector,
	output logic                                  irq
);
	import adir_pkg::*;

	////////////////////////////////////////////////////////////////
	// bus slave state
	logic                  wr_ff;
	logic                  rd_ff;
	logic [ADIR_IDX_W-1:0] idx_ff;
	logic [31:0]           hrdata_ff;
	logic                  nxt_wr;
	logic                  nxt_rd;
	logic [ADIR_IDX_W-1:0] nxt_idx;
	logic [31:0]           nxt_hrdata;
	logic                  addr_take;

	////////////////////////////////////////////////////////////////
	// register state
	logic                       conv_done_flag_ff;
	logic                       limit_violation_flag_ff;
	logic                       conversion_done_irq_enable_ff;
	logic                       limit_violation_irq_enable_ff;
	logic [ADIR_PRIO_W-1:0]     irq_priority_level_ff;
	logic [ADIR_VEC_BASE_W-1:0] vec_base_ff;
	logic [ADIR_SRC_N-1:0]      status_ff;
	logic [ADIR_SRC_N-1:0]      mask_ff;
	logic                       nxt_conv_done_flag;
	logic                       nxt_limit_violation_flag;
	logic                       nxt_conv_en;
	logic                       nxt_lim_en;
	logic [ADIR_PRIO_W-1:0]     nxt_prio;
	logic [ADIR_VEC_BASE_W-1:0] nxt_vec_base;
	logic [ADIR_SRC_N-1:0]      nxt_status;
	logic [ADIR_SRC_N-1:0]      nxt_mask;

	logic                   wr_ctrl;
	logic                   wr_vec;
	logic                   wr_status;
	logic                   wr_mask;
	logic [ADIR_DATA_W-1:0] wbyte;
	logic [ADIR_DATA_W-1:0] ctrl_rd;
	logic [ADIR_DATA_W-1:0] vec_rd;
	logic                   conv_set;
	logic                   lim_set;
	logic [ADIR_SRC_N-1:0]  evt_set;

	adir_arb_if arb_if ();

	adir_arbiter adir_arbiter_inst (
		.hclk    (hclk),
		.hresetn (hresetn),
		.arb     (arb_if.arb)
	);

	////////////////////////////////////////////////////////////////
	// ahb-lite address and data phase tracking
	// reads take one wait state so a write just before is always seen
	assign addr_take = hsel && hready && (htrans == ADIR_HTRANS_NONSEQ);

	always_comb begin
		nxt_wr     = 1'b0;
		nxt_rd     = 1'b0;
		nxt_idx    = idx_ff;
		nxt_hrdata = hrdata_ff;
		if (addr_take) begin
			nxt_wr  = hwrite;
			nxt_rd  = !hwrite;
			nxt_idx = haddr[ADIR_IDX_W+1:2];
		end
		if (rd_ff) begin
			unique case (idx_ff)
				ADIR_CTRL_IDX: begin
					nxt_hrdata = {24'h000000, ctrl_rd};
				end
				ADIR_VEC_IDX: begin
					nxt_hrdata = {24'h000000, vec_rd};
				end
				ADIR_STATUS_IDX: begin
					nxt_hrdata = {30'h00000000, status_ff};
				end
				ADIR_MASK_IDX: begin
					nxt_hrdata = {30'h00000000, mask_ff};
				end
				default: begin
					nxt_hrdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff     <= 1'b0;
			rd_ff     <= 1'b0;
			idx_ff    <= '0;
			hrdata_ff <= 32'h00000000;
		end else begin
			wr_ff     <= nxt_wr;
			rd_ff     <= nxt_rd;
			idx_ff    <= nxt_idx;
			hrdata_ff <= nxt_hrdata;
		end
	end

	assign hreadyout = !rd_ff;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;

	////////////////////////////////////////////////////////////////
	// write strobes and read views
	assign wbyte     = hwdata[ADIR_DATA_W-1:0];
	assign wr_ctrl   = wr_ff && (idx_ff == ADIR_CTRL_IDX);
	assign wr_vec    = wr_ff && (idx_ff == ADIR_VEC_IDX);
	assign wr_status = wr_ff && (idx_ff == ADIR_STATUS_IDX);
	assign wr_mask   = wr_ff && (idx_ff == ADIR_MASK_IDX);

	// reserved bit 3 reads as one, matching the 0Fh reset view
	assign ctrl_rd = {conv_done_flag_ff, limit_violation_flag_ff,
		conversion_done_irq_enable_ff, limit_violation_irq_enable_ff,
		1'b1, irq_priority_level_ff};

	assign vec_rd = {vec_base_ff, arb_if.word_sel, 1'b0};

	////////////////////////////////////////////////////////////////
	// event flags and control fields
	assign conv_set = conv_group_done
		|| (wr_ctrl && wbyte[ADIR_CTRL_CONV_FLAG_BIT]);
	assign lim_set  = limit_violation
		|| (wr_ctrl && wbyte[ADIR_CTRL_LIM_FLAG_BIT]);

	always_comb begin
		nxt_conv_done_flag       = conv_done_flag_ff;
		nxt_limit_violation_flag = limit_violation_flag_ff;
		nxt_conv_en              = conversion_done_irq_enable_ff;
		nxt_lim_en               = limit_violation_irq_enable_ff;
		nxt_prio                 = irq_priority_level_ff;
		nxt_vec_base             = vec_base_ff;
		if (wr_ctrl) begin
			// software clear of a flag, used by the handler on exit
			nxt_conv_done_flag       = wbyte[ADIR_CTRL_CONV_FLAG_BIT];
			nxt_limit_violation_flag = wbyte[ADIR_CTRL_LIM_FLAG_BIT];
			nxt_conv_en              = wbyte[ADIR_CTRL_CONV_EN_BIT];
			nxt_lim_en               = wbyte[ADIR_CTRL_LIM_EN_BIT];
			nxt_prio                 = wbyte[ADIR_CTRL_PRIO_LSB +: ADIR_PRIO_W];
		end
		// hardware set beats a simultaneous clear so no event is lost
		if (conv_set) begin
			nxt_conv_done_flag = 1'b1;
		end
		if (lim_set) begin
			nxt_limit_violation_flag = 1'b1;
		end
		if (wr_vec) begin
			nxt_vec_base = wbyte[ADIR_VEC_BASE_LSB +: ADIR_VEC_BASE_W];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv_done_flag_ff             <= 1'b0;
			limit_violation_flag_ff       <= 1'b0;
			conversion_done_irq_enable_ff <= 1'b0;
			limit_violation_irq_enable_ff <= 1'b0;
			irq_priority_level_ff         <= ADIR_PRIO_RST;
			vec_base_ff                   <= ADIR_VEC_BASE_RST;
		end else begin
			conv_done_flag_ff             <= nxt_conv_done_flag;
			limit_violation_flag_ff       <= nxt_limit_violation_flag;
			conversion_done_irq_enable_ff <= nxt_conv_en;
			limit_violation_irq_enable_ff <= nxt_lim_en;
			irq_priority_level_ff         <= nxt_prio;
			vec_base_ff                   <= nxt_vec_base;
		end
	end

	////////////////////////////////////////////////////////////////
	// sticky event status, write one to clear, set wins
	always_comb begin
		evt_set                    = '0;
		evt_set[ADIR_EVT_CONV_BIT] = conv_set;
		evt_set[ADIR_EVT_LIM_BIT]  = lim_set;
		nxt_status = status_ff;
		nxt_mask   = mask_ff;
		if (wr_status) begin
			nxt_status = status_ff & ~wbyte[ADIR_SRC_N-1:0];
		end
		nxt_status = nxt_status | evt_set;
		if (wr_mask) begin
			nxt_mask = wbyte[ADIR_SRC_N-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_ff <= ADIR_STATUS_RST;
			mask_ff   <= ADIR_MASK_RST;
		end else begin
			status_ff <= nxt_status;
			mask_ff   <= nxt_mask;
		end
	end

	assign irq = |(status_ff & mask_ff);

	////////////////////////////////////////////////////////////////
	// requests toward the cpu interrupt handler
	assign arb_if.conv_req = conv_done_flag_ff && conversion_done_irq_enable_ff;
	assign arb_if.lim_req  = limit_violation_flag_ff && limit_violation_irq_enable_ff;

	assign cpu_irq_req        = arb_if.req_any;
	assign irq_priority_level = irq_priority_level_ff;
	assign irq_vector         = vec_rd;

endmodule

// ===== dv/adir_assertions.sv
`timescale 1ns/10ps
module adir_chk (
	input wire logic                             hclk,
	input wire logic                             hresetn,
	input wire logic                             hsel,
	input wire logic [31:0]                      haddr,
	input wire logic [1:0]                       htrans,
	input wire logic                             hwrite,
	input wire logic [31:0]                      hwdata,
	input wire logic                             hready,
	input wire logic                             conv_group_done,
	input wire logic                             limit_violation,
	input wire logic                             cpu_irq_req,
	input wire logic [adir_pkg::ADIR_PRIO_W-1:0] irq_priority_level,
	input wire logic [adir_pkg::ADIR_DATA_W-1:0] irq_vector
);
	import adir_pkg::*;
	logic wp_ff;
	logic ce_ff;
	logic le_ff;
	logic nxt_wp;
	logic nxt_ce;
	logic nxt_le;
	// mirror of the enables, taken from control write data phases
	always_comb begin
		nxt_wp = hsel && hready && htrans == ADIR_HTRANS_NONSEQ && hwrite
			&& haddr[11:2] == ADIR_CTRL_IDX;
		nxt_ce = wp_ff ? hwdata[5] : ce_ff;
		nxt_le = wp_ff ? hwdata[4] : le_ff;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_ff <= 1'b0;
			ce_ff <= 1'b0;
			le_ff <= 1'b0;
		end else begin
			wp_ff <= nxt_wp;
			ce_ff <= nxt_ce;
			le_ff <= nxt_le;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_lim;
		cpu_irq_req ##1 !irq_vector[ADIR_VEC_WSEL_BIT];
	endsequence
	AST_CONV_EN: assert property (
		conv_group_done && ce_ff && !wp_ff |=> cpu_irq_req) else $error("conv req missing");
	AST_LIM_EN: assert property (
		limit_violation && le_ff && !wp_ff |=> s_lim) else $error("limit req wrong");
	AST_BOTH: assert property (
		conv_group_done && limit_violation && ce_ff && le_ff && !wp_ff |=> s_lim)
		else $error("limit not first");
	AST_MASKED: assert property (
		!ce_ff && !le_ff |-> !cpu_irq_req) else $error("masked req seen");
	AST_HOLD_OFF: assert property (
		!cpu_irq_req && !conv_group_done && !limit_violation && !wp_ff |=> !cpu_irq_req)
		else $error("req without cause");
	AST_SW_REQ: assert property (
		wp_ff && hwdata[7] && hwdata[5] |=> cpu_irq_req) else $error("sw req missing");
	AST_PRIO: assert property (
		wp_ff |=> irq_priority_level == $past(hwdata[2:0])) else $error("prio wrong");
	AST_BIT0: assert property (
		!irq_vector[0]) else $error("vector bit0 set");
	AST_RST_VEC: assert property (
		$rose(hresetn) |-> irq_vector[1:0] == 2'h2) else $error("vector reset wrong");
endmodule
bind adir_top adir_chk adir_chk_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .conv_group_done, .limit_violation, .cpu_irq_req,
	.irq_priority_level, .irq_vector);

// ===== dv/adir_cpu_model.sv
`timescale 1ns/10ps
module adir_cpu_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       cpu_irq_req,
	input  wire logic [7:0] irq_vector,
	output logic            fetch_ff,
	output logic      [7:0] fetch_addr_ff
);
	// handler fetches the table entry one cycle after the request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fetch_ff      <= 1'b0;
			fetch_addr_ff <= 8'h00;
		end else begin
			fetch_ff      <= cpu_irq_req;
			fetch_addr_ff <= irq_vector;
		end
	end
endmodule

// ===== dv/test_adc_interrupt_request_logic.sv
`timescale 1ns/10ps
module test_adc_interrupt_request_logic;
	import adir_pkg::*;
	logic        hclk    = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel    = 1'b0;
	logic        hwrite  = 1'b0;
	logic        cdone   = 1'b0;
	logic        lviol   = 1'b0;
	logic        dphase  = 1'b0;
	logic        look_on = 1'b0;
	logic [1:0]  htrans  = 2'h0;
	logic [31:0] haddr   = 32'h0;
	logic [31:0] hwdata  = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, cpu_irq_req, irq, fetch_ff;
	logic [2:0]  prio, p;
	logic [7:0]  vec, fadr, b;
	logic [7:0]  exp_q[$];
	string       nam_q[$];
	string       cur_n;
	int          fails       = 0;
	int          checks_done = 0;
	integer      seed        = 32'h18D060F6;
	always #2 hclk = ~hclk;
	adir_top adir_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .conv_group_done(cdone),
		.limit_violation(lviol), .cpu_irq_req, .irq_priority_level(prio), .irq_vector(vec), .irq);
	adir_cpu_model adir_cpu_model_inst (.hclk, .hresetn, .cpu_irq_req, .irq_vector(vec),
		.fetch_ff, .fetch_addr_ff(fadr));
	////////////////////////////////////////////////////////////////
	task final_report;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	// what the monitor looks at for each kind of note
	function automatic logic [7:0] seen(input string n);
		if (n == "hrdata") begin
			return hrdata[7:0];
		end
		if (n == "hresp") begin
			return {7'h00, hresp};
		end
		if (n == "prio") begin
			return {5'h00, prio};
		end
		if (n == "fetch") begin
			return fadr;
		end
		if (n == "fetch_req") begin
			return {7'h00, fetch_ff};
		end
		return {5'h00, cpu_irq_req, irq, vec[1]};
	endfunction
	task note(input string n, input logic [7:0] e);
		nam_q.push_back(n);
		exp_q.push_back(e);
	endtask
	// for a read, d is the expected byte; no wait count assumed
	task bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= ADIR_HTRANS_NONSEQ;
		hwrite <= w;
		haddr  <= {20'h0, idx, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		note("hresp", 8'h00);
		if (!w) begin
			note("hrdata", d);
		end
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		dphase <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		dphase <= 1'b0;
	endtask
	task look(input string n, input logic [7:0] e);
		@(posedge hclk);
		note(n, e);
		look_on <= 1'b1;
		@(posedge hclk);
		look_on <= 1'b0;
	endtask
	task pulse(input logic c, input logic l);
		@(posedge hclk);
		cdone <= c;
		lviol <= l;
		@(posedge hclk);
		cdone <= 1'b0;
		lviol <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask
	// notes are pushed only at edges where this does not fire, so no race
	always @(posedge hclk) begin
		if (look_on || (dphase && hreadyout === 1'b1)) begin
			while (nam_q.size() > 0) begin
				cur_n = nam_q.pop_front();
				chk(cur_n, exp_q.pop_front(), seen(cur_n));
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge hclk);
		fails++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		p = 3'($random(seed));
		b = 8'($random(seed));
		bus(0, ADIR_CTRL_IDX, 8'h0F);
		bus(0, ADIR_VEC_IDX, 8'h02);
		bus(0, ADIR_STATUS_IDX, 8'h00);
		bus(0, ADIR_MASK_IDX, 8'h00);
		bus(0, 10'h003, 8'h00);
		bus(1, ADIR_CTRL_IDX, {5'h00, p});
		bus(1, ADIR_VEC_IDX, b | 8'h03);
		bus(0, ADIR_VEC_IDX, (b & 8'hFC) | 8'h02);
		look("prio", {5'h00, p});
		pulse(1, 0);
		look("outs", 8'h01);
		bus(0, ADIR_CTRL_IDX, 8'h88 | p);
		bus(0, ADIR_STATUS_IDX, 8'h01);
		bus(1, ADIR_MASK_IDX, 8'h03);
		bus(1, ADIR_CTRL_IDX, 8'hA0 | p);
		repeat (2) @(posedge hclk);
		look("outs", 8'h07);
		bus(1, ADIR_STATUS_IDX, 8'h01);
		pulse(0, 1);
		look("outs", 8'h07);
		bus(0, ADIR_CTRL_IDX, 8'hE8 | p);
		bus(0, ADIR_STATUS_IDX, 8'h02);
		bus(1, ADIR_STATUS_IDX, 8'h02);
		bus(1, ADIR_CTRL_IDX, 8'h30 | p);
		look("outs", 8'h01);
		pulse(1, 1);
		look("outs", 8'h06);
		look("fetch_req", 8'h01);
		look("fetch", b & 8'hFC);
		bus(1, ADIR_CTRL_IDX, 8'hB0 | p);
		repeat (2) @(posedge hclk);
		look("outs", 8'h07);
		bus(1, ADIR_MASK_IDX, 8'h00);
		look("outs", 8'h05);
		bus(1, ADIR_STATUS_IDX, 8'h03);
		bus(0, ADIR_STATUS_IDX, 8'h00);
		bus(1, ADIR_CTRL_IDX, 8'h30 | p);
		bus(1, ADIR_CTRL_IDX, 8'h70 | p);
		repeat (2) @(posedge hclk);
		look("outs", 8'h04);
		bus(0, ADIR_STATUS_IDX, 8'h02);
		bus(1, ADIR_CTRL_IDX, {5'h00, p});
		look("outs", 8'h00);
		// mid-run reset while word select is clear: it must come back set
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, ADIR_VEC_IDX, 8'h02);
		bus(0, ADIR_CTRL_IDX, 8'h0F);
		final_report();
	end
endmodule
